// ---- hw/external_sram_interface.sv ----
// external sram interface with muxed address/data bus and axi4-lite registers
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module external_sram_interface
    import ext_mem_iface_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // axi4-lite slave
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // core data-space request
    input wire logic req_valid_in,
    input wire mem_req_t req_in,
    output logic req_ready_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    // external pins
    output logic [7:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe_out,
    input wire logic [7:0] muxed_addr_data_bus_in,
    output logic [7:0] muxed_pullup_en_out,
    output logic muxed_keeper_en_out,
    output logic [7:0] high_address_byte_out,
    output logic [7:0] high_address_byte_oe_out,
    output logic strobe_out,
    output logic read_n_out,
    output logic write_n_out
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] high_byte_port_out;
    logic [7:0] high_byte_port_dir;
    logic [7:0] next_ctrl_a;
    logic [7:0] next_ctrl_b;
    logic [7:0] next_port_out;
    logic [7:0] next_port_dir;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_awready;
    logic next_wready;
    logic next_arready;
    logic busy;

    function automatic logic [7:0] lane_merge(input logic [7:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        lane_merge = strb[0] ? data[7:0] : old;
    endfunction : lane_merge

    function automatic logic known_offset(input logic [7:0] off);
        known_offset = (off == OFF_CTRL_A) || (off == OFF_CTRL_B) ||
                       (off == OFF_PORT_OUT) || (off == OFF_PORT_DIR) ||
                       (off == OFF_STATUS);
    endfunction : known_offset

    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_port_out = high_byte_port_out;
        next_port_dir = high_byte_port_dir;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid_out;
        next_bresp = bresp_out;
        next_rvalid = rvalid_out;
        next_rdata = rdata_out;
        next_rresp = rresp_out;
        if (awvalid_in && awready_out) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_w_held = 1'b1;
            next_w_data = wdata_in;
            next_w_strb = wstrb_in;
        end
        if (aw_held && w_held && !bvalid_out) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = known_offset(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (aw_addr)
                OFF_CTRL_A: next_ctrl_a = lane_merge(ctrl_a, w_data, w_strb);
                OFF_CTRL_B: next_ctrl_b = lane_merge(ctrl_b, w_data, w_strb);
                OFF_PORT_OUT: next_port_out = lane_merge(high_byte_port_out, w_data, w_strb);
                OFF_PORT_DIR: next_port_dir = lane_merge(high_byte_port_dir, w_data, w_strb);
                default: begin
                end
            endcase
        end else if (bvalid_out && bready_in) begin
            next_bvalid = 1'b0;
        end
        if (arvalid_in && arready_out) begin
            next_rvalid = 1'b1;
            next_rresp = known_offset(araddr_in) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr_in)
                OFF_CTRL_A: next_rdata = {24'h000000, ctrl_a};
                OFF_CTRL_B: next_rdata = {24'h000000, ctrl_b};
                OFF_PORT_OUT: next_rdata = {24'h000000, high_byte_port_out};
                OFF_PORT_DIR: next_rdata = {24'h000000, high_byte_port_dir};
                OFF_STATUS: next_rdata = {31'h00000000, busy};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (rvalid_out && rready_in) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_a <= CTRL_A_RESET;
            ctrl_b <= CTRL_B_RESET;
            high_byte_port_out <= PORT_RESET;
            high_byte_port_dir <= PORT_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out <= RESP_OKAY;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h00000000;
            rresp_out <= RESP_OKAY;
            awready_out <= 1'b0;
            wready_out <= 1'b0;
            arready_out <= 1'b0;
        end else if (ce_in) begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            high_byte_port_out <= next_port_out;
            high_byte_port_dir <= next_port_dir;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid_out <= next_bvalid;
            bresp_out <= next_bresp;
            rvalid_out <= next_rvalid;
            rdata_out <= next_rdata;
            rresp_out <= next_rresp;
            awready_out <= next_awready;
            wready_out <= next_wready;
            arready_out <= next_arready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus sequencer
    bus_state_t state;
    bus_state_t next_state;
    mem_req_t cur;
    mem_req_t next_cur;
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic [1:0] wait_sel;
    logic [7:0] last_drive;
    logic [7:0] next_last_drive;
    pins_t pins;
    pins_t next_pins;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic next_req_ready;
    logic [7:0] mask_bits;
    logic [7:0] next_hi_oe;
    logic take;

    wait_select u_wait_select (
        .addr_in(req_in.addr),
        .sector_limit_in(ctrl_a[SECTOR_LIMIT_POS +: 4]),
        .lower_wait_in(ctrl_a[LOWER_WAIT_POS +: 2]),
        .upper_wait_in(ctrl_a[UPPER_WAIT_POS +: 2]),
        .wait_out(wait_sel)
    );

    // mask code n releases the top n address pins, code zero none
    always_comb begin
        unique case (ctrl_b[MASK_POS +: 3])
            3'h0: mask_bits = 8'h00;
            3'h1: mask_bits = 8'h80;
            3'h2: mask_bits = 8'hc0;
            3'h3: mask_bits = 8'he0;
            3'h4: mask_bits = 8'hf0;
            3'h5: mask_bits = 8'hf8;
            3'h6: mask_bits = 8'hfc;
            3'h7: mask_bits = 8'hfe;
        endcase
    end

    assign busy = (state != SEC_IDLE);
    // internal space never produces an external cycle
    assign take = req_valid_in && req_ready_out && (req_in.addr >= EXT_BASE);

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_wait_cnt = wait_cnt;
        next_last_drive = last_drive;
        next_pins = pins;
        next_rd_data = rd_data_out;
        next_rd_valid = 1'b0;
        next_req_ready = 1'b0;
        unique case (state)
            SEC_IDLE: begin
                next_req_ready = 1'b1;
                next_pins.strobe = 1'b0;
                if (take) begin
                    next_cur = req_in;
                    next_wait_cnt = wait_sel;
                    next_pins.strobe = 1'b1;
                    next_pins.lo_out = req_in.addr[7:0];
                    next_pins.lo_oe = 1'b1;
                    next_pins.hi_out = req_in.addr[15:8];
                    next_last_drive = req_in.addr[7:0];
                    next_req_ready = 1'b0;
                    next_state = SEC_ADDR;
                end
            end
            SEC_ADDR: begin
                // strobe falls here; the external latch holds the address
                next_pins.strobe = 1'b0;
                if (cur.write) begin
                    next_pins.lo_out = cur.wdata;
                    next_pins.lo_oe = 1'b1;
                    next_pins.write_n = 1'b0;
                    next_last_drive = cur.wdata;
                end else begin
                    next_pins.lo_oe = 1'b0;
                    next_pins.read_n = 1'b0;
                end
                next_state = SEC_DATA;
            end
            SEC_DATA: begin
                if (wait_cnt != 2'h0) begin
                    next_wait_cnt = wait_cnt - 2'h1;
                end else begin
                    // zero wait select ends after one data period
                    if (!cur.write) begin
                        next_rd_data = muxed_addr_data_bus_in;
                        next_rd_valid = 1'b1;
                    end
                    next_pins.read_n = 1'b1;
                    next_pins.write_n = 1'b1;
                    next_pins.lo_oe = 1'b0;
                    // trailing strobe only ahead of another ram access
                    next_pins.strobe = cur.next_is_ram;
                    next_state = SEC_TAIL;
                end
            end
            SEC_TAIL: begin
                next_pins.strobe = 1'b0;
                next_req_ready = 1'b1;
                next_state = SEC_IDLE;
            end
        endcase
    end

    // released top pins show the port value and port direction
    always_comb begin
        next_hi_oe = mask_bits & high_byte_port_dir;
        next_hi_oe = next_hi_oe | ~mask_bits;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= SEC_IDLE;
            cur <= '0;
            wait_cnt <= 2'h0;
            last_drive <= 8'h00;
            pins <= '{lo_out: 8'h00, lo_oe: 1'b0, hi_out: 8'h00, strobe: 1'b0,
                      read_n: 1'b1, write_n: 1'b1};
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
            req_ready_out <= 1'b0;
            muxed_addr_data_bus_out <= 8'h00;
            muxed_addr_data_bus_oe_out <= 1'b0;
            muxed_pullup_en_out <= 8'h00;
            muxed_keeper_en_out <= 1'b0;
            high_address_byte_out <= 8'h00;
            high_address_byte_oe_out <= 8'h00;
            strobe_out <= 1'b0;
            read_n_out <= 1'b1;
            write_n_out <= 1'b1;
        end else if (ce_in) begin
            state <= next_state;
            cur <= next_cur;
            wait_cnt <= next_wait_cnt;
            last_drive <= next_last_drive;
            pins <= next_pins;
            rd_data_out <= next_rd_data;
            rd_valid_out <= next_rd_valid;
            req_ready_out <= next_req_ready;
            // keeper replays the last driven byte while the bus is released
            muxed_addr_data_bus_out <= next_pins.lo_oe ? next_pins.lo_out : next_last_drive;
            muxed_addr_data_bus_oe_out <= next_pins.lo_oe;
            muxed_pullup_en_out <= next_port_out;
            muxed_keeper_en_out <= next_ctrl_b[KEEPER_POS];
            high_address_byte_out <= (next_pins.hi_out & ~mask_bits) |
                                     (next_port_out & mask_bits);
            high_address_byte_oe_out <= next_hi_oe;
            strobe_out <= next_pins.strobe;
            read_n_out <= next_pins.read_n;
            write_n_out <= next_pins.write_n;
        end
    end
endmodule : external_sram_interface

// ---- hw/wait_select.sv ----
// picks the wait setting for an address from the two sector fields
`timescale 1ns/1ns
module wait_select
    import ext_mem_iface_pkg::*;
(
    input wire logic [15:0] addr_in,
    input wire logic [3:0] sector_limit_in,
    input wire logic [1:0] lower_wait_in,
    input wire logic [1:0] upper_wait_in,
    output logic [1:0] wait_out
);
    // limit zero keeps one sector over the whole space
    always_comb begin
        if (sector_limit_in != 4'h0 && addr_in[15:12] >= sector_limit_in) begin
            wait_out = upper_wait_in;
        end else begin
            wait_out = lower_wait_in;
        end
    end
endmodule : wait_select

// ---- include/ext_mem_iface_pkg.sv ----
// constants and types for the external sram interface
//
// Notes on behaviour
// - muxed lines get pull-ups while matching port output bits are one.
// - keeper holds last driven level while the muxed lines are released.
// - a software bit switches the bus keeper on and off.
// - two-bit wait select gives four cycle lengths for reads and writes.
// - address space splits into lower and upper sector, each own wait.
// - upper sector uses upper wait bits, lower sector uses lower bits.
// - wait select zero means no added wait state.
// - trailing latch strobe only when the next access targets ram.
// - no external access for addresses below 0x2200.
// - by default only 56 KB external space is reachable.
// - mask bits return top address pins to port function and port value.
package ext_mem_iface_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_PORT_OUT = 8'h08;
    localparam logic [7:0] OFF_PORT_DIR = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // ctrl_a fields
    localparam int SECTOR_LIMIT_POS = 0;
    localparam int LOWER_WAIT_POS = 4;
    localparam int UPPER_WAIT_POS = 6;
    // ctrl_b fields
    localparam int MASK_POS = 0;
    localparam int KEEPER_POS = 7;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // first external address; below it memory is internal
    localparam logic [15:0] EXT_BASE = 16'h2200;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic next_is_ram;
    } mem_req_t;

    typedef struct packed {
        logic [7:0] lo_out;
        logic lo_oe;
        logic [7:0] hi_out;
        logic strobe;
        logic read_n;
        logic write_n;
    } pins_t;

    typedef enum logic [1:0] {
        SEC_IDLE,
        SEC_ADDR,
        SEC_DATA,
        SEC_TAIL
    } bus_state_t;
endpackage : ext_mem_iface_pkg

// ---- tb/external_sram_interface_tb.sv ----
// testbench for the external sram interface
`timescale 1ns/1ns
module external_sram_interface_tb;
    import ext_mem_iface_pkg::*;
    logic mclk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1;
    logic awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0, arvalid_in = 1'h0;
    logic rready_in = 1'h0, req_valid_in = 1'h0;
    logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wstrb_in = 4'h1;
    mem_req_t req_in = '0;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, req_ready_out;
    logic rd_valid_out, muxed_addr_data_bus_oe_out, muxed_keeper_en_out;
    logic strobe_out, read_n_out, write_n_out;
    logic [1:0] bresp_out, rresp_out;
    logic [31:0] rdata_out;
    logic [7:0] rd_data_out, muxed_addr_data_bus_out, muxed_addr_data_bus_in;
    logic [7:0] muxed_pullup_en_out, high_address_byte_out, high_address_byte_oe_out;
    int mismatches = 0, cmp_count = 0;

    external_sram_interface dut (.*);
    // slow memory: data settles well after the strobe edge
    sram_model #(.DLY_NS(20)) u_sram (.clk_in(mclk_in), .bus_in(muxed_addr_data_bus_out),
        .oe_in(muxed_addr_data_bus_oe_out), .keep_in(muxed_keeper_en_out),
        .strobe_in(strobe_out), .hi_in(high_address_byte_out), .read_n_in(read_n_out),
        .write_n_in(write_n_out), .wire_out(muxed_addr_data_bus_in));

    always #25 mclk_in = ~mclk_in;
    ////////////////////////////////////////
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo(input int k);
        if (k >= 60) begin
            mismatches++;
            summarize();
        end
    endtask : tmo

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge mclk_in);
        awaddr_in <= a;
        wdata_in <= {24'h000000, d};
        awvalid_in <= 1'h1;
        wvalid_in <= 1'h1;
        bready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            k++;
            if (awready_out) awvalid_in <= 1'h0;
            if (wready_out) wvalid_in <= 1'h0;
        end while (!bvalid_out && k < 60);
        r = bresp_out;
        bready_in <= 1'h0;
        tmo(k);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge mclk_in);
        araddr_in <= a;
        arvalid_in <= 1'h1;
        rready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            k++;
            if (arready_out) arvalid_in <= 1'h0;
        end while (!rvalid_out && k < 60);
        d = rdata_out;
        r = rresp_out;
        rready_in <= 1'h0;
        tmo(k);
    endtask : rd

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(r, RESP_OKAY);
        repeat (2) @(posedge mclk_in);
    endtask : wreg

    // n counts cycles with a read or write strobe low; q is the returned byte
    task automatic mreq(input logic [15:0] a, input logic [7:0] d, input logic w,
                        output logic [7:0] q, output int n);
        int k;
        k = 0;
        n = 0;
        q = 8'h00;
        @(posedge mclk_in);
        req_in <= '{addr: a, wdata: d, write: w, next_is_ram: a[0]};
        req_valid_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            k++;
        end while (!req_ready_out && k < 60);
        req_valid_in <= 1'h0;
        tmo(k);
        repeat (10) begin
            @(posedge mclk_in);
            if (!read_n_out || !write_n_out) n++;
            if (rd_valid_out) q = rd_data_out;
        end
    endtask : mreq
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk_in);
        mismatches++;
        summarize();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] q;
        int n;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'h0;
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4), d, r);
            chk(d, 32'h0);
            chk(r, RESP_OKAY);
        end
        rd(8'h14, d, r);
        chk(r, RESP_SLVERR);
        wr(8'h14, 8'hff, r);
        chk(r, RESP_SLVERR);
        wreg(OFF_PORT_OUT, 8'ha5);
        chk(muxed_pullup_en_out, 8'ha5);
        wreg(OFF_PORT_OUT, 8'h00);
        chk(muxed_pullup_en_out, 8'h00);
        wreg(OFF_CTRL_B, 8'h80);
        chk(muxed_keeper_en_out, 1'h1);
        $display("register test done");
        for (int w = 0; w < 4; w++) begin
            wreg(OFF_CTRL_A, 8'(w << LOWER_WAIT_POS));
            mreq(16'h2300 + 16'(w), 8'(8'h3c + w), 1'h1, q, n);
            chk(n, w + 1);
            mreq(16'h2300 + 16'(w), 8'h00, 1'h0, q, n);
            chk(n, w + 1);
            chk(q, 8'h3c + w);
        end
        $display("wait test done");
        wreg(OFF_CTRL_A, 8'hc8);
        mreq(16'h9000, 8'h77, 1'h1, q, n);
        chk(n, 4);
        mreq(16'h3000, 8'h66, 1'h1, q, n);
        chk(n, 1);
        mreq(16'h9000, 8'h00, 1'h0, q, n);
        chk(q, 8'h77);
        mreq(16'h21ff, 8'h11, 1'h1, q, n);
        chk(n, 0);
        mreq(16'h1000, 8'h11, 1'h0, q, n);
        chk(n, 0);
        $display("sector test done");
        wreg(OFF_CTRL_B, 8'h82);
        chk(high_address_byte_oe_out, 8'h3f);
        wreg(OFF_PORT_DIR, 8'hff);
        chk(high_address_byte_oe_out, 8'hff);
        mreq(16'h4001, 8'haa, 1'h1, q, n);
        chk(u_sram.mem[16'h0001], 8'haa);
        wreg(OFF_CTRL_B, 8'h80);
        mreq(16'h4001, 8'h55, 1'h1, q, n);
        chk(u_sram.mem[16'h4001], 8'h55);
        $display("mask test done");
        rst_in <= 1'h1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'h0;
        rd(OFF_CTRL_B, d, r);
        chk(d, 32'h0);
        chk(muxed_keeper_en_out, 1'h0);
        $display("reset test done");
        summarize();
    end
endmodule : external_sram_interface_tb

// ---- tb/sram_iface_monitor.sv ----
// port checker for the external sram interface
`timescale 1ns/1ns
module sram_iface_monitor
    import ext_mem_iface_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire mem_req_t req_in,
    input wire logic req_ready_out,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic [7:0] muxed_addr_data_bus_out,
    input wire logic muxed_addr_data_bus_oe_out,
    input wire logic [7:0] muxed_addr_data_bus_in,
    input wire logic [7:0] muxed_pullup_en_out,
    input wire logic [7:0] high_address_byte_out,
    input wire logic [7:0] high_address_byte_oe_out,
    input wire logic strobe_out,
    input wire logic read_n_out,
    input wire logic write_n_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic take, ext, nir, next_nir;
    logic [15:0] sav, next_sav;
    assign take = req_valid_in && req_ready_out;
    assign ext = req_in.addr >= EXT_BASE;
    // remember the accepted request so later cycles can be tied to it
    always_comb begin
        next_nir = take ? req_in.next_is_ram : nir;
        next_sav = take ? req_in.addr : sav;
    end
    always_ff @(posedge mclk_in) begin
        nir <= next_nir;
        sav <= next_sav;
    end
    ////////////////////////////////////////
    lo_addr_a: assert property (take && ext |=> strobe_out && muxed_addr_data_bus_oe_out
        && muxed_addr_data_bus_out == sav[7:0]) else $error("low address not on bus");
    // each driven high pin shows its address bit, or its port bit once released
    hi_addr_a: assert property (take && ext |=> (((high_address_byte_out ^ sav[15:8])
        & (high_address_byte_out ^ muxed_pullup_en_out)) & high_address_byte_oe_out) == 8'h00)
        else $error("high address wrong");
    no_internal_a: assert property (take && !ext |=>
        (!strobe_out && read_n_out && write_n_out)[*3]) else $error("internal access went out");
    strobe_pulse_a: assert property (strobe_out |=> !strobe_out)
        else $error("strobe longer than one cycle");
    read_len_a: assert property ($fell(read_n_out) |-> ##[1:4] read_n_out)
        else $error("read strobe too long");
    read_cap_a: assert property (rd_valid_out |-> !$past(read_n_out)
        && rd_data_out == $past(muxed_addr_data_bus_in)) else $error("read byte wrong");
    tail_strobe_a: assert property (rd_valid_out |-> strobe_out == nir)
        else $error("tail strobe wrong");
    write_drive_a: assert property (!write_n_out |->
        muxed_addr_data_bus_oe_out && read_n_out) else $error("write without drive");
    keeper_hold_a: assert property (!muxed_addr_data_bus_oe_out
        && !$past(muxed_addr_data_bus_oe_out) |-> $stable(muxed_addr_data_bus_out))
        else $error("released bus changed");
    cover property (take && ext && req_in.write);
    cover property (rd_valid_out && strobe_out);
    cover property (take && !ext);
endmodule : sram_iface_monitor

bind external_sram_interface sram_iface_monitor mon (.*);

// ---- tb/sram_model.sv ----
// external sram behind an address latch, with the pad level of the muxed bus
`timescale 1ns/1ns
module sram_model #(parameter int DLY_NS = 0) (
    input wire logic clk_in,
    input wire logic [7:0] bus_in,
    input wire logic oe_in,
    input wire logic keep_in,
    input wire logic strobe_in,
    input wire logic [7:0] hi_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    output logic [7:0] wire_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat;
    logic [7:0] w;
    logic [7:0] last = 8'h00;
    // an undriven bus without keeper toggles so stale data never looks valid
    always_comb begin
        if (oe_in) w = bus_in;
        else if (!read_n_in) w = mem[{hi_in, lat}];
        else if (keep_in) w = last;
        else w = ~last;
    end
    assign #(DLY_NS) wire_out = w;
    always_ff @(posedge clk_in) begin
        last <= wire_out;
        if (strobe_in) lat <= wire_out;
        if (!write_n_in) mem[{hi_in, lat}] <= wire_out;
    end
endmodule : sram_model
